//--- rtl/rwdc_illegal_fetch.v
// illegal instruction fetch detector
// assumes fetch strobe and address are synchronous to the core clock
`timescale 1ns/1ns
`default_nettype none
`include "rwdc_defines.vh"

module rwdc_illegal_fetch (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_fetch_vld,
    input wire [15:0] i_fetch_addr,
    output reg o_illegal_ff
);

    wire in_io;
    wire in_unimp;
    wire in_monrom;
    wire nxt_illegal;

    // range compares; io low bound is zero so only upper bound matters
    assign in_io = (i_fetch_addr <= `RWDC_IO_HI);
    assign in_unimp = ((i_fetch_addr >= `RWDC_UNIMP1_LO) && (i_fetch_addr <= `RWDC_UNIMP1_HI)) ||
                      ((i_fetch_addr >= `RWDC_UNIMP2_LO) && (i_fetch_addr <= `RWDC_UNIMP2_HI));
    assign in_monrom = (i_fetch_addr >= `RWDC_MONROM_LO) && (i_fetch_addr <= `RWDC_MONROM_HI);
    assign nxt_illegal = i_fetch_vld && (in_io || in_unimp || in_monrom);

    // one-cycle registered request; pulldown stretch covers the rest
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_illegal_ff <= 1'b0;
        end else begin
            o_illegal_ff <= nxt_illegal;
        end
    end

endmodule
`default_nettype wire

//--- rtl/rwdc_reset_ctrl.v
// reset and watchdog control top: merges five reset sources
// assumes pin level, por and lvr flags are already synchronous to i_core_clk
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "rwdc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - five sources, pin plus four internal, all drive the common reset
// - reset held while pin low; run resumes the cycle after pin rises
// - every source turns on pin pulldown for 3-4 cycles or longer
// - external pin assertion also turns pulldown on for 3-4 cycles
// - internal reset holds pin low while the condition lasts, then 4 more cycles
// - power-on holds reset 4064 bus cycles after oscillator becomes active
// - reset stays asserted past por delay while another source is active
// - free-running watchdog resets device unless software clears it
// - watchdog exists only when the build-time option enables it
// - writing zero to bit 0 of the clear location restarts watchdog
// - reads of clear location return the build-time vector byte, no watchdog state
// - watchdog keeps counting in wait state
// - after watchdog reset mode comes from mode pins like any reset
// - fetch from unimplemented, monitor rom or io space raises reset
// - low-voltage detector is the fourth internal source and pulls pin down
module rwdc_reset_ctrl #(
    parameter WDOG_EN = 1,
    parameter WDOG_TIMEOUT_CYC = 65536,
    parameter WDOG_CW = 17,
    parameter POR_DELAY_CYC = `RWDC_POR_DELAY_CYC,
    parameter [7:0] VEC_BYTE = `RWDC_VEC_BYTE_RST
) (
    input wire i_core_clk,
    input wire i_srst,
    // reset pin: level in, open-drain pulldown out
    input wire i_rst_pin_n,
    output wire o_rst_pin_o,
    output wire o_rst_pin_oe,
    // analog detector flags, already synchronised
    input wire i_por_flag,
    input wire i_low_voltage_reset,
    input wire i_osc_active,
    // mode pins sampled at reset release
    input wire i_mode_pin_irq_hv,
    input wire i_mode_pin_pb0,
    // cpu fetch monitor
    input wire i_fetch_vld,
    input wire [15:0] i_fetch_addr,
    // register port
    input wire [15:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata_ff,
    // results
    output reg o_core_rst_ff,
    output reg o_monitor_mode_ff,
    output reg [2:0] o_rst_cause_ff
);

    localparam ST_POR = 3'b001;
    localparam ST_HOLD = 3'b010;
    localparam ST_RUN = 3'b100;
    localparam PW = 13;
    localparam DW = 3;
    // stretch load value held at the counter's own width
    localparam [DW-1:0] PD_LOAD = `RWDC_PULLDOWN_CYC;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [PW-1:0] por_cnt_ff;
    reg [PW-1:0] nxt_por_cnt;
    reg [DW-1:0] pd_cnt_ff;
    reg [DW-1:0] nxt_pd_cnt;
    reg pin_low_d_ff;
    reg wdog_src_ff;
    wire wdog_timeout;
    wire illegal_fetch;
    wire wdog_clear;
    wire int_src;
    wire pin_low;
    wire pin_fall;
    wire any_src;
    wire por_done;

    ////////////////////////////////////////////////////////////////////////////
    // sub-blocks

    // write of zero to bit 0 of the clear location restarts the watchdog
    assign wdog_clear = i_reg_wr && (i_reg_addr == `RWDC_WDOG_CLR_ADDR) &&
                        !i_reg_wdata[`RWDC_WDOG_CLR_BIT];

    rwdc_watchdog #(
        .EN(WDOG_EN),
        .TIMEOUT_CYC(WDOG_TIMEOUT_CYC),
        .CW(WDOG_CW)
    ) u_wdog (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst || o_core_rst_ff),
        .i_clear(wdog_clear),
        .o_timeout_ff(wdog_timeout)
    );

    rwdc_illegal_fetch u_ill (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst || o_core_rst_ff),
        .i_fetch_vld(i_fetch_vld),
        .i_fetch_addr(i_fetch_addr),
        .o_illegal_ff(illegal_fetch)
    );

    ////////////////////////////////////////////////////////////////////////////
    // source merge

    // the watchdog pulse is held until the pulldown stretch has started
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            wdog_src_ff <= 1'b0;
        end else begin
            wdog_src_ff <= wdog_timeout;
        end
    end

    assign pin_low = !i_rst_pin_n;
    // internal sources: power-on, watchdog, illegal fetch, low voltage
    assign int_src = i_por_flag || wdog_timeout || wdog_src_ff || illegal_fetch ||
                     i_low_voltage_reset;
    assign any_src = int_src || pin_low;
    assign pin_fall = pin_low && !pin_low_d_ff;

    // previous pin level for the fall detector; reset as low because the
    // pulldown is on during reset, so no false fall follows release
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            pin_low_d_ff <= 1'b1;
        end else begin
            pin_low_d_ff <= pin_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulldown stretcher: reloads while an internal source stays up

    // our own pulldown reads back as pin low, so only the fall edge reloads
    // for the pin; otherwise it would latch itself on forever
    always @* begin
        nxt_pd_cnt = pd_cnt_ff;
        if (int_src || (state_ff == ST_POR)) begin
            nxt_pd_cnt = PD_LOAD;
        end else if (pin_fall && (pd_cnt_ff == {DW{1'b0}})) begin
            nxt_pd_cnt = PD_LOAD;
        end else if (pd_cnt_ff != {DW{1'b0}}) begin
            nxt_pd_cnt = pd_cnt_ff - {{(DW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            pd_cnt_ff <= PD_LOAD;
        end else begin
            pd_cnt_ff <= nxt_pd_cnt;
        end
    end

    assign o_rst_pin_o = 1'b0;
    assign o_rst_pin_oe = (pd_cnt_ff != {DW{1'b0}});

    ////////////////////////////////////////////////////////////////////////////
    // power-on delay and reset state machine

    assign por_done = (por_cnt_ff == POR_DELAY_CYC[PW-1:0]);

    // por counts only while the oscillator runs and the por flag has dropped
    always @* begin
        nxt_state = state_ff;
        nxt_por_cnt = por_cnt_ff;
        case (state_ff)
            ST_POR: begin
                if (i_por_flag) begin
                    nxt_por_cnt = {PW{1'b0}};
                end else if (i_osc_active && !por_done) begin
                    nxt_por_cnt = por_cnt_ff + {{(PW-1){1'b0}}, 1'b1};
                end
                if (por_done && !i_por_flag) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (i_por_flag) begin
                    nxt_state = ST_POR;
                    nxt_por_cnt = {PW{1'b0}};
                end else if (!any_src && !o_rst_pin_oe) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (i_por_flag) begin
                    nxt_state = ST_POR;
                    nxt_por_cnt = {PW{1'b0}};
                end else if (any_src) begin
                    nxt_state = ST_HOLD;
                end
            end
            default: begin
                nxt_state = ST_POR;
                nxt_por_cnt = {PW{1'b0}};
            end
        endcase
    end

    // core reset: asserted in every state but run
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            state_ff <= ST_POR;
            por_cnt_ff <= {PW{1'b0}};
            o_core_rst_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            por_cnt_ff <= nxt_por_cnt;
            o_core_rst_ff <= (nxt_state != ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode capture and cause record

    // mode latched from pins on every release, watchdog reset included
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_monitor_mode_ff <= 1'b0;
        end else if (o_core_rst_ff && (nxt_state == ST_RUN)) begin
            o_monitor_mode_ff <= i_mode_pin_irq_hv && i_mode_pin_pb0;
        end
    end

    // cause bits: {watchdog, illegal fetch, low voltage}; last internal reset wins, pin reset leaves them
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_rst_cause_ff <= 3'h0;
        end else if ((state_ff == ST_RUN) && int_src) begin
            o_rst_cause_ff <= {wdog_timeout, illegal_fetch, i_low_voltage_reset};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read: the clear location is also a vector byte

    // no watchdog state ever shows; vector byte is a build constant here
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_reg_rdata_ff <= 8'h00;
        end else if (i_reg_rd && (i_reg_addr == `RWDC_WDOG_CLR_ADDR)) begin
            o_reg_rdata_ff <= VEC_BYTE;
        end else begin
            o_reg_rdata_ff <= 8'h00;
        end
    end

endmodule
`default_nettype wire

//--- rtl/rwdc_watchdog.v
// watchdog counter with software clear
// assumes clear is a one-cycle pulse, enable fixed at build time
`timescale 1ns/1ns
`default_nettype none

module rwdc_watchdog #(
    parameter EN = 1,
    parameter TIMEOUT_CYC = 65536,
    parameter CW = 17
) (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_clear,
    output reg o_timeout_ff
);

    reg [CW-1:0] cnt_ff;
    wire [CW-1:0] nxt_cnt;
    wire hit;

    // keeps counting in wait too: there is no wait input on purpose
    assign hit = (cnt_ff == TIMEOUT_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});
    assign nxt_cnt = (i_clear || hit) ? {CW{1'b0}} : cnt_ff + {{(CW-1){1'b0}}, 1'b1};

    // counter and timeout pulse; gated off entirely when not built in
    always @(posedge i_core_clk) begin
        if (i_srst || (EN == 0)) begin
            cnt_ff <= {CW{1'b0}};
            o_timeout_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            o_timeout_ff <= hit && !i_clear;
        end
    end

endmodule
`default_nettype wire

//--- shared/rwdc_defines.vh
// reset and watchdog control: offsets, address ranges, timing counts
// assumes a 20 MHz internal processor clock and a 16-bit cpu address
`ifndef RWDC_DEFINES_VH
`define RWDC_DEFINES_VH

// register map
`define RWDC_WDOG_CLR_ADDR 16'h3ff0
`define RWDC_WDOG_CLR_BIT 0
`define RWDC_VEC_BYTE_RST 8'h00

// pulldown stretch: 3-4 internal clock cycles, take 4
`define RWDC_PULLDOWN_CYC 4

// power-on oscillator stabilisation delay in internal bus cycles
`define RWDC_POR_DELAY_CYC 4064

// illegal fetch ranges (inclusive)
`define RWDC_IO_LO 16'h0000
`define RWDC_IO_HI 16'h004f
`define RWDC_UNIMP1_LO 16'h0150
`define RWDC_UNIMP1_HI 16'h03ff
`define RWDC_UNIMP2_LO 16'h0500
`define RWDC_UNIMP2_HI 16'h0fff
`define RWDC_MONROM_LO 16'h3f00
`define RWDC_MONROM_HI 16'h3fef

`endif

//--- verif/rwdc_pin_model.sv
// reset pin wire: pull-up, outside reset circuit, device pulldown
// assumes device oe high means it drives the pin
`timescale 1ns/1ns
`default_nettype none
module rwdc_pin_model (
    input wire logic i_ext_low,
    input wire logic i_pin_oe,
    input wire logic i_pin_o,
    output logic o_pin_n
);
// pull-up wins only when nobody pulls down
assign o_pin_n = !((i_pin_oe && !i_pin_o) || i_ext_low);
endmodule
`default_nettype wire

//--- verif/rwdc_reset_ctrl_asserts.sv
// checker for the reset and watchdog control ports
// assumes a bind onto rwdc_reset_ctrl, one core clock domain
`timescale 1ns/1ns
`default_nettype none
`include "rwdc_defines.vh"
module rwdc_reset_ctrl_asserts #(
    parameter int WDOG_TIMEOUT_CYC = 64,
    parameter int POR_DELAY_CYC = 16,
    parameter [7:0] VEC_BYTE = 8'h00
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_rst_pin_n,
    input wire logic o_rst_pin_o,
    input wire logic o_rst_pin_oe,
    input wire logic i_por_flag,
    input wire logic i_low_voltage_reset,
    input wire logic i_osc_active,
    input wire logic i_fetch_vld,
    input wire logic [15:0] i_fetch_addr,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata_ff,
    input wire logic o_core_rst_ff
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_srst);
int por_cnt_ff;
int wd_cnt_ff;
logic bad_fetch;
////////////////////////////////////////////////////////////////////////////////
// fetch into a forbidden range
assign bad_fetch = i_fetch_vld && (i_fetch_addr <= `RWDC_IO_HI ||
    (i_fetch_addr >= `RWDC_UNIMP1_LO && i_fetch_addr <= `RWDC_UNIMP1_HI) ||
    (i_fetch_addr >= `RWDC_UNIMP2_LO && i_fetch_addr <= `RWDC_UNIMP2_HI) ||
    (i_fetch_addr >= `RWDC_MONROM_LO && i_fetch_addr <= `RWDC_MONROM_HI));
// oscillator cycles since power-on, cycles since last watchdog clear
always_ff @(posedge i_core_clk) begin
    if (i_srst || i_por_flag)
        por_cnt_ff <= 0;
    else if (i_osc_active && por_cnt_ff < POR_DELAY_CYC)
        por_cnt_ff <= por_cnt_ff + 1;
    if (i_srst || o_core_rst_ff || (i_reg_wr && i_reg_addr == `RWDC_WDOG_CLR_ADDR && !i_reg_wdata[0]))
        wd_cnt_ff <= 0;
    else
        wd_cnt_ff <= wd_cnt_ff + 1;
end
////////////////////////////////////////////////////////////////////////////////
chk_pin_hold: assert property (!i_rst_pin_n |=> o_core_rst_ff) else $error("pin low without reset");
chk_pin_data: assert property (o_rst_pin_o == 1'b0) else $error("pin data not low");
chk_ext_stretch: assert property ($fell(i_rst_pin_n) && !o_rst_pin_oe |=> o_rst_pin_oe [*3])
    else $error("outside reset pulldown too short");
chk_lvr_pull: assert property (i_low_voltage_reset |-> ##[1:3] (o_rst_pin_oe && o_core_rst_ff))
    else $error("low voltage without reset");
chk_oe_stretch: assert property ($fell(i_low_voltage_reset) |-> o_rst_pin_oe ##1 o_rst_pin_oe)
    else $error("pulldown dropped with source");
chk_release_clean: assert property ($fell(o_core_rst_ff) |-> $past(i_rst_pin_n) && !$past(o_rst_pin_oe)
    && !$past(i_low_voltage_reset)) else $error("reset left with source active");
chk_por_delay: assert property (o_core_rst_ff || por_cnt_ff >= POR_DELAY_CYC) else $error("power-on delay short");
chk_fetch_rst: assert property (bad_fetch && !o_core_rst_ff |-> ##[1:3] o_core_rst_ff)
    else $error("illegal fetch without reset");
chk_vec_read: assert property (i_reg_rd && i_reg_addr == `RWDC_WDOG_CLR_ADDR |=> o_reg_rdata_ff == VEC_BYTE)
    else $error("clear location read wrong");
chk_other_read: assert property (i_reg_rd && i_reg_addr != `RWDC_WDOG_CLR_ADDR |=> o_reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
chk_wdog_bound: assert property (wd_cnt_ff < WDOG_TIMEOUT_CYC + 4) else $error("watchdog never fired");
endmodule
`default_nettype wire

//--- verif/rwdc_reset_ctrl_test.sv
// testbench for reset and watchdog control, register port tasks
// assumes short por and watchdog counts set by parameter
`timescale 1ns/1ns
`default_nettype none
module rwdc_reset_ctrl_test;
localparam int TMO = 64;
localparam int POR = 16;
localparam logic [7:0] VEC = 8'ha5;
localparam logic [15:0] CLR = 16'h3ff0;
logic clk = 0, srst = 1, ext_low = 0, por = 1, low_voltage_reset = 0, osc = 0, m_irq = 1, m_pb0 = 1;
logic fvld = 0, wr = 0, rd = 0;
logic [15:0] faddr = 16'h0000, addr = 16'h0000;
logic [7:0] wdata = 8'h00;
wire logic pin_n, pin_o, pin_oe, core_rst, mon;
wire logic [7:0] rdata;
wire logic [2:0] cause;
int errors = 0, n_compared = 0, i, n;
logic [15:0] tbl [9] = '{16'h0000, 16'h004f, 16'h0150, 16'h03ff, 16'h0500, 16'h0fff, 16'h3f00, 16'h3fef, 16'h0050};
rwdc_reset_ctrl #(.WDOG_TIMEOUT_CYC(TMO), .WDOG_CW(7), .POR_DELAY_CYC(POR), .VEC_BYTE(VEC)) dut (
    .i_core_clk(clk), .i_srst(srst), .i_rst_pin_n(pin_n), .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe),
    .i_por_flag(por), .i_low_voltage_reset(low_voltage_reset), .i_osc_active(osc), .i_mode_pin_irq_hv(m_irq),
    .i_mode_pin_pb0(m_pb0), .i_fetch_vld(fvld), .i_fetch_addr(faddr), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata_ff(rdata), .o_core_rst_ff(core_rst), .o_monitor_mode_ff(mon),
    .o_rst_cause_ff(cause));
rwdc_pin_model pin (.i_ext_low(ext_low), .i_pin_oe(pin_oe), .i_pin_o(pin_o), .o_pin_n(pin_n));
// 20 MHz core clock
initial forever #25 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// idle edge after each strobe keeps back-to-back calls legal
task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
endtask
task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
    @(posedge clk);
endtask
// bounded wait for the internal reset level, sampled mid-cycle
task automatic wait_for(input logic lvl, input int bound);
    for (n = 0; n < bound; n++) begin
        @(negedge clk);
        if (core_rst === lvl)
            break;
        @(posedge clk);
    end
    @(posedge clk);
    if (n == bound) begin
        errors++;
        $display("ERROR t=%0t rst=%h exp=%h", $time, core_rst, lvl);
        finish_test();
    end
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    osc <= 1'b1;
    low_voltage_reset <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    repeat (POR + 8) @(posedge clk);
    @(negedge clk);
    check(core_rst, 1'b1);
    @(posedge clk);
    low_voltage_reset <= 1'b0;
    wait_for(1'b0, 20);
    check(mon, 1'b1);
    rd_chk(CLR, VEC);
    rd_chk(16'h3ff1, 8'h00);
    wr_reg(CLR, 8'hfe);
    rd_chk(CLR, VEC);
    m_irq <= 1'b0;
    for (i = 0; i < 6; i++) begin
        wr_reg(CLR, 8'hfe);
        repeat (40) @(posedge clk);
    end
    @(negedge clk);
    check(core_rst, 1'b0);
    @(posedge clk);
    wr_reg(CLR, 8'h01);
    wait_for(1'b1, TMO + 8);
    wait_for(1'b0, 20);
    check(cause, 3'b100);
    check(mon, 1'b0);
    // outside reset pulse of one cycle
    wr_reg(CLR, 8'hfe);
    ext_low <= 1'b1;
    @(posedge clk);
    ext_low <= 1'b0;
    wait_for(1'b1, 3);
    check(pin_oe, 1'b1);
    check(pin_o, 1'b0);
    wait_for(1'b0, 20);
    // low-voltage source held longer than the stretch
    wr_reg(CLR, 8'hfe);
    low_voltage_reset <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({pin_oe, core_rst}, 2'b11);
    @(posedge clk);
    low_voltage_reset <= 1'b0;
    wait_for(1'b0, 20);
    check(cause, 3'b001);
    // every boundary of the forbidden fetch ranges, then a legal one
    for (i = 0; i < 9; i++) begin
        wr_reg(CLR, 8'hfe);
        faddr <= tbl[i];
        fvld <= 1'b1;
        @(posedge clk);
        fvld <= 1'b0;
        if (i < 8) begin
            wait_for(1'b1, 4);
            wait_for(1'b0, 20);
            check(cause, 3'b010);
        end else begin
            repeat (5) @(posedge clk);
            @(negedge clk);
            check(core_rst, 1'b0);
            @(posedge clk);
        end
    end
    // second reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wait_for(1'b0, POR + 20);
    finish_test();
end
endmodule
bind rwdc_reset_ctrl rwdc_reset_ctrl_asserts #(.WDOG_TIMEOUT_CYC(WDOG_TIMEOUT_CYC), .POR_DELAY_CYC(POR_DELAY_CYC),
    .VEC_BYTE(VEC_BYTE)) u_chk (.i_core_clk, .i_srst, .i_rst_pin_n, .o_rst_pin_o, .o_rst_pin_oe, .i_por_flag,
    .i_low_voltage_reset, .i_osc_active, .i_fetch_vld, .i_fetch_addr, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata_ff, .o_core_rst_ff);
`default_nettype wire
